// ==== test_two_wire_eeprom_slave.sv ====
// self-checking bench for the two-wire eeprom target
`timescale 1ns/1ns
module test_two_wire_eeprom_slave;
   import tws_pkg::*;
   localparam int PCYC = 4000;
   logic clk, link_clk, resetn, ce, scl, ctl_sda, sda_w, sda_o, sda_oe_n, standby;
   logic program_busy, a;
   logic [7:0] q;
   int err_total, total_checks;
   // open-drain wire with pull-up
   assign sda_w = (sda_oe_n === 1'b0 || ctl_sda === 1'b0) ? 1'b0 : 1'b1;
   tws_eeprom #(.PROGRAM_CYCLES(PCYC)) dut (.clk(clk), .resetn(resetn), .ce(ce),
      .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .standby(standby), .program_busy(program_busy));
   tws_ctl_model ctl (.link_clk(link_clk), .sda_w(sda_w), .scl_o(scl), .sda_o(ctl_sda));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic snd(input logic [7:0] d, input logic ea);
      ctl.xfer(d, 1'b1, q, a);
      chk(8'(a), 8'(ea));
   endtask : snd
   task automatic wr(input logic [6:0] ad, input logic [7:0] dq[$]);
      ctl.start();
      snd({ad, DIR_WRITE}, ACK_LEVEL);
      foreach (dq[i])
         snd(dq[i], ACK_LEVEL);
      ctl.stop();
   endtask : wr
   task automatic rd(input logic [6:0] ad, input logic [7:0] eq[$]);
      ctl.start();
      snd({ad, 1'b1}, ACK_LEVEL);
      foreach (eq[i])
      begin
         ctl.xfer(8'hFF, i == eq.size() - 1, q, a);
         chk(q, eq[i]);
      end
      ctl.stop();
      chk(8'(standby), 8'h01);
   endtask : rd
   task automatic wait_done;
      for (int i = 0; i < 2 * PCYC && standby !== 1'b1; i++)
         @(negedge clk);
      chk(8'(standby), 8'h01);
   endtask : wait_done
   task automatic t_byte;
      chk({standby, program_busy, sda_oe_n, sda_o, 4'h0}, 8'hA0);
      rd(7'h05, '{8'h00});
      wr(7'h10, '{8'hA5});
      chk(8'(program_busy), 8'h01);
      ctl.start();
      snd({7'h10, DIR_WRITE}, SDA_RELEASE);
      ctl.stop();
      wait_done();
      ctl.start();
      snd({7'h10, DIR_WRITE}, ACK_LEVEL);
      ctl.stop();
      chk(8'(program_busy), 8'h00);
      rd(7'h10, '{8'hA5});
      $display("byte test done");
   endtask : t_byte
   task automatic t_page;
      wr(7'h22, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
      wait_done();
      rd(7'h20, '{8'h33, 8'h44, 8'h55, 8'h22});
      wr(7'h7F, '{8'h3C});
      wait_done();
      rd(7'h7F, '{8'h3C, 8'h00});
      $display("page test done");
   endtask : t_page
   task automatic t_abort;
      ctl.start();
      repeat (4) ctl.bit_io(1'b0, a);
      ctl.stop();
      chk(8'(standby), 8'h01);
      repeat (9) ctl.bit_io(1'b1, a);
      chk(8'(a), 8'h01);
      ctl.start();
      snd({7'h23, DIR_WRITE}, ACK_LEVEL);
      rd(7'h23, '{8'h22});
      chk(8'(program_busy), 8'h00);
      $display("abort test done");
   endtask : t_abort
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   initial
   begin
      err_total = 0;
      total_checks = 0;
      ce = 1'b1;
      resetn = 1'b0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      repeat (80) @(negedge clk);
      t_byte();
      t_page();
      t_abort();
      report_and_stop();
   end
   initial
   begin
      // run needs some 60k cycles; allow half again
      repeat (90000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
endmodule : test_two_wire_eeprom_slave

// ==== tws_ctl_model.sv ====
// bus controller model for the two-wire eeprom target
`timescale 1ns/1ns
module tws_ctl_model
(
   input wire logic link_clk,
   input wire logic sda_w,
   output logic scl_o,
   output logic sda_o
);
   // released data reads high by the pull-up; clock stands high when idle
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic drv(input logic c, input logic d, input int n);
      scl_o = c;
      sda_o = d;
      repeat (n) @(negedge link_clk);
   endtask : drv
   // data moves in clock low, sampled late in clock high
   task automatic bit_io(input logic b, output logic r);
      drv(1'b0, b, 5);
      drv(1'b1, b, 8);
      r = sda_w;
      drv(1'b1, b, 2);
      drv(1'b0, b, 5);
   endtask : bit_io
   task automatic start;
      drv(scl_o, 1'b1, 5);
      drv(1'b1, 1'b1, 10);
      drv(1'b1, 1'b0, 10);
      drv(1'b0, 1'b0, 5);
   endtask : start
   task automatic stop;
      drv(1'b0, 1'b0, 5);
      drv(1'b1, 1'b0, 10);
      drv(1'b1, 1'b1, 10);
   endtask : stop
   // msb first, ninth clock carries the acknowledge
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
      output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ak, a);
   endtask : xfer
endmodule : tws_ctl_model

// ==== tws_eeprom.sv ====
// two-wire serial eeprom target: link engine, storage and program timer
`timescale 1ns/1ns
module tws_eeprom
   import tws_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DFLT,
   parameter int PAGE_W = PAGE_W_DFLT,
   parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DFLT
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   output logic standby,
   output logic program_busy
);

   localparam int DEPTH = 1 << ADDR_W;
   localparam int PAGE_BYTES = 1 << PAGE_W;
   localparam int ROW_W = ADDR_W - PAGE_W;

   typedef struct packed {
      tws_state_t state;
      logic [3:0] bit_cnt;
      logic [WORD_W-1:0] rx_shift;
      logic [WORD_W-1:0] tx_shift;
      logic [ADDR_W-1:0] addr;
      logic dir;
      logic [ROW_W-1:0] row;
      logic [PAGE_BYTES-1:0][WORD_W-1:0] page_buf;
      logic [PAGE_BYTES-1:0] page_valid;
      logic req_tgl;
      logic done_seen;
      logic scl_d;
      logic sda_d;
      logic sda_oe_n;
      logic sda_o;
      logic standby;
      logic stop_armed;
      logic [DEPTH-1:0][WORD_W-1:0] mem;
   } tws_link_st_t;

   typedef struct packed {
      logic req_seen;
      logic done_tgl;
      logic busy;
      logic [31:0] cnt;
   } tws_prog_st_t;

   tws_link_st_t link_reg;
   tws_link_st_t link_next;
   tws_prog_st_t prog_reg;
   tws_prog_st_t prog_next;

   logic scl_s;
   logic sda_s;
   logic ce_link;
   logic done_s;
   logic req_s;
   logic link_busy;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [ADDR_W-1:0] addr_next_seq;
   logic [ADDR_W-1:0] addr_next_page;

   // pins are asynchronous to the link clock
   tws_sync #(.W(2)) u_pin_sync (
      .clk(link_clk),
      .resetn(resetn),
      .en(ce_link),
      .d({scl_i, sda_i}),
      .q({scl_s, sda_s})
   );

   // the enable itself is never frozen
   tws_sync #(.W(1)) u_ce_sync (
      .clk(link_clk),
      .resetn(resetn),
      .en(1'b1),
      .d(ce),
      .q(ce_link)
   );

   tws_sync #(.W(1)) u_done_sync (
      .clk(link_clk),
      .resetn(resetn),
      .en(ce_link),
      .d(prog_reg.done_tgl),
      .q(done_s)
   );

   tws_sync #(.W(1)) u_req_sync (
      .clk(clk),
      .resetn(resetn),
      .en(ce),
      .d(link_reg.req_tgl),
      .q(req_s)
   );

   // line events from synchronised samples only
   assign scl_rise = scl_s && !link_reg.scl_d;
   assign scl_fall = !scl_s && link_reg.scl_d;
   assign start_seen = scl_s && link_reg.scl_d && link_reg.sda_d && !sda_s;
   assign stop_seen = scl_s && link_reg.scl_d && !link_reg.sda_d && sda_s;

   // busy until the finished page is committed to storage
   assign link_busy = link_reg.req_tgl != link_reg.done_seen;

   assign addr_next_seq = link_reg.addr + ADDR_W'(1);
   assign addr_next_page = {link_reg.addr[ADDR_W-1:PAGE_W],
                            link_reg.addr[PAGE_W-1:0] + PAGE_W'(1)};

   always_comb
   begin
      link_next = link_reg;
      link_next.scl_d = scl_s;
      link_next.sda_d = sda_s;
      link_next.sda_o = SDA_OUT_LEVEL;
      link_next.standby = link_reg.stop_armed && (link_reg.state == ST_IDLE) &&
                          !link_busy;

      // program cycle over: write the held page into the array
      if (done_s != link_reg.done_seen)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
         begin
            if (link_reg.page_valid[i])
            begin
               link_next.mem[{link_reg.row, i[PAGE_W-1:0]}] = link_reg.page_buf[i];
            end
         end
         link_next.page_valid = '0;
         link_next.done_seen = done_s;
      end

      if (start_seen)
      begin
         // a start wins in any state
         link_next.state = ST_ADDR;
         link_next.stop_armed = 1'b0;
         link_next.bit_cnt = BIT_CNT_ZERO;
         link_next.sda_oe_n = SDA_RELEASE;
      end
      else if (stop_seen)
      begin
         if ((link_reg.state == ST_WDATA || link_reg.state == ST_WDATA_ACK) &&
             (link_reg.page_valid != '0))
         begin
            link_next.req_tgl = ~link_reg.req_tgl;
         end
         link_next.state = ST_IDLE;
         link_next.stop_armed = 1'b1;
         link_next.sda_oe_n = SDA_RELEASE;
      end
      else if (scl_rise && link_reg.state != ST_IDLE)
      begin
         link_next.rx_shift = {link_reg.rx_shift[WORD_W-2:0], sda_s};
         link_next.bit_cnt = link_reg.bit_cnt + BIT_CNT_STEP;
      end
      else if (scl_fall)
      begin
         case (link_reg.state)
            ST_IDLE:
            begin
               link_next.sda_oe_n = SDA_RELEASE;
            end
            ST_ADDR:
            begin
               if (link_reg.bit_cnt == BITS_PER_WORD)
               begin
                  link_next.bit_cnt = BIT_CNT_ZERO;
                  if (link_busy)
                  begin
                     // no answer while programming runs
                     link_next.state = ST_IDLE;
                     link_next.sda_oe_n = SDA_RELEASE;
                  end
                  else
                  begin
                     link_next.addr = link_reg.rx_shift[WORD_W-1:1];
                     link_next.row = link_reg.rx_shift[WORD_W-1:PAGE_W+1];
                     link_next.dir = link_reg.rx_shift[0];
                     link_next.page_valid = '0;
                     link_next.sda_oe_n = SDA_PULL_LOW;
                     link_next.state = ST_ADDR_ACK;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               link_next.bit_cnt = BIT_CNT_ZERO;
               if (link_reg.dir == DIR_WRITE)
               begin
                  link_next.sda_oe_n = SDA_RELEASE;
                  link_next.state = ST_WDATA;
               end
               else
               begin
                  // first read bit goes out on the falling edge ending the ack
                  link_next.tx_shift = link_reg.mem[link_reg.addr];
                  link_next.sda_oe_n = link_reg.mem[link_reg.addr][WORD_W-1];
                  link_next.state = ST_RDATA;
               end
            end
            ST_WDATA:
            begin
               if (link_reg.bit_cnt == BITS_PER_WORD)
               begin
                  link_next.page_buf[link_reg.addr[PAGE_W-1:0]] = link_reg.rx_shift;
                  link_next.page_valid[link_reg.addr[PAGE_W-1:0]] = 1'b1;
                  link_next.addr = addr_next_page;
                  link_next.sda_oe_n = SDA_PULL_LOW;
                  link_next.bit_cnt = BIT_CNT_ZERO;
                  link_next.state = ST_WDATA_ACK;
               end
            end
            ST_WDATA_ACK:
            begin
               link_next.sda_oe_n = SDA_RELEASE;
               link_next.bit_cnt = BIT_CNT_ZERO;
               link_next.state = ST_WDATA;
            end
            ST_RDATA:
            begin
               if (link_reg.bit_cnt == BITS_PER_WORD)
               begin
                  // controller owns the line for the ninth clock
                  link_next.sda_oe_n = SDA_RELEASE;
                  link_next.bit_cnt = BIT_CNT_ZERO;
                  link_next.state = ST_RDATA_ACK;
               end
               else
               begin
                  link_next.tx_shift = {link_reg.tx_shift[WORD_W-2:0], 1'b0};
                  link_next.sda_oe_n = link_reg.tx_shift[WORD_W-2];
               end
            end
            ST_RDATA_ACK:
            begin
               link_next.bit_cnt = BIT_CNT_ZERO;
               if (link_reg.rx_shift[0] == ACK_LEVEL)
               begin
                  link_next.addr = addr_next_seq;
                  link_next.tx_shift = link_reg.mem[addr_next_seq];
                  link_next.sda_oe_n = link_reg.mem[addr_next_seq][WORD_W-1];
                  link_next.state = ST_RDATA;
               end
               else
               begin
                  // nack: wait quietly for the stop
                  link_next.sda_oe_n = SDA_RELEASE;
                  link_next.state = ST_IDLE;
               end
            end
            default:
            begin
               link_next.state = ST_IDLE;
               link_next.sda_oe_n = SDA_RELEASE;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         link_reg <= '0;
         link_reg.state <= ST_IDLE;
         link_reg.sda_oe_n <= SDA_RELEASE;
         link_reg.sda_o <= SDA_OUT_LEVEL;
         link_reg.standby <= 1'b1;
         link_reg.stop_armed <= 1'b1;
      end
      else if (ce_link)
      begin
         link_reg <= link_next;
      end
   end

   // program timer on the system clock
   always_comb
   begin
      prog_next = prog_reg;
      if (prog_reg.busy)
      begin
         if (prog_reg.cnt == 32'(PROGRAM_CYCLES - 1))
         begin
            prog_next.busy = 1'b0;
            prog_next.cnt = '0;
            prog_next.done_tgl = ~prog_reg.done_tgl;
         end
         else
         begin
            prog_next.cnt = prog_reg.cnt + 32'h1;
         end
      end
      else if (req_s != prog_reg.req_seen)
      begin
         prog_next.req_seen = req_s;
         prog_next.busy = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prog_reg <= '0;
      end
      else if (ce)
      begin
         prog_reg <= prog_next;
      end
   end

   assign sda_o = link_reg.sda_o;
   assign sda_oe_n = link_reg.sda_oe_n;
   assign standby = link_reg.standby;
   assign program_busy = prog_reg.busy;

endmodule : tws_eeprom

// ==== tws_eeprom_checker.sv ====
// port assertions for the eeprom target
`timescale 1ns/1ns
module tws_eeprom_checker
   import tws_pkg::*;
#(
   parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DFLT
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic standby,
   input wire logic program_busy
);
   logic [31:0] n_reg;
   // run length of busy; frozen with ce like the timer
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         n_reg <= 32'h0;
      else if (ce)
         n_reg <= program_busy ? n_reg + 32'h1 : 32'h0;
   end
   busy_len_a: assert property (@(posedge clk) disable iff (!resetn)
      $fell(program_busy) |-> n_reg == 32'(PROGRAM_CYCLES)) else $error("busy len");
   busy_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      program_busy |-> sda_oe_n && sda_o == SDA_OUT_LEVEL) else $error("busy drive");
   busy_awake_a: assert property (@(posedge clk) disable iff (!resetn)
      program_busy |-> !standby) else $error("busy standby");
   idle_rel_a: assert property (@(posedge link_clk) disable iff (!resetn)
      standby |-> sda_oe_n) else $error("standby drive");
   idle_rise_a: assert property (@(posedge link_clk) disable iff (!resetn)
      $rose(standby) |-> scl_i && sda_i) else $error("standby bus busy");
   oe_fall_a: assert property (@(posedge link_clk) disable iff (!resetn)
      $fell(sda_oe_n) |-> !scl_i) else $error("pull in high");
   oe_steady_a: assert property (@(posedge link_clk) disable iff (!resetn)
      scl_i && $past(scl_i) |-> $stable(sda_oe_n)) else $error("move in high");
   oe_hold_a: assert property (@(posedge link_clk) disable iff (!resetn)
      $fell(sda_oe_n) |=> !sda_oe_n [*6]) else $error("pull short");
   cover property (@(posedge clk) $fell(program_busy));
   cover property (@(posedge link_clk) $fell(sda_oe_n));
   cover property (@(posedge link_clk) $rose(standby));
endmodule : tws_eeprom_checker

bind tws_eeprom tws_eeprom_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (.clk(clk),
   .resetn(resetn), .ce(ce), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n), .standby(standby), .program_busy(program_busy));

// ==== tws_pkg.sv ====
// shared constants and types for the two-wire eeprom target
package tws_pkg;

   localparam int ADDR_W_DFLT = 7;
   localparam int PAGE_W_DFLT = 2;
   localparam int WORD_W = 8;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_STEP = 4'h1;

   // programming time in its own unit, and the system clock rate
   localparam int PROGRAM_CYCLE_TIME_US = 5000;
   localparam int CLK_FREQ_MHZ = 50;
   localparam int PROGRAM_CYCLES_DFLT = PROGRAM_CYCLE_TIME_US * CLK_FREQ_MHZ;

   localparam logic SDA_RELEASE = 1'b1;
   localparam logic SDA_PULL_LOW = 1'b0;
   localparam logic SDA_OUT_LEVEL = 1'b0;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic ACK_LEVEL = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } tws_state_t;

endpackage : tws_pkg

// ==== tws_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ns
module tws_sync
   import tws_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } tws_sync_st_t;

   tws_sync_st_t state_reg;
   tws_sync_st_t state_next;

   // first stage is read only by the second stage
   always_comb
   begin
      state_next = state_reg;
      if (en)
      begin
         state_next.meta = d;
         state_next.stable = state_reg.meta;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign q = state_reg.stable;

endmodule : tws_sync
